// file: dtc_params.svh
// Constants for the dual timer/counter block: bit positions, reset values and counts.
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// System clocks in one peripheral cycle.
`define DTC_PERIPH_CLKS 4'hC
`define DTC_PERIPH_LAST 4'hB

// Field positions in the timer mode register.
`define DTC_TIMER_MODE_REG_T0_MODE_LO 0
`define DTC_TIMER_MODE_REG_T0_MODE_HI 1
`define DTC_TIMER_MODE_REG_T0_CSEL 2
`define DTC_TIMER_MODE_REG_T0_GATE 3
`define DTC_TIMER_MODE_REG_T1_MODE_LO 4
`define DTC_TIMER_MODE_REG_T1_MODE_HI 5
`define DTC_TIMER_MODE_REG_T1_CSEL 6
`define DTC_TIMER_MODE_REG_T1_GATE 7

// Field positions in the timer control register view.
`define DTC_TIMER_CONTROL_REG_IT0 0
`define DTC_TIMER_CONTROL_REG_IE0 1
`define DTC_TIMER_CONTROL_REG_IT1 2
`define DTC_TIMER_CONTROL_REG_IE1 3
`define DTC_TIMER_CONTROL_REG_TR0 4
`define DTC_TIMER_CONTROL_REG_TF0 5
`define DTC_TIMER_CONTROL_REG_TR1 6
`define DTC_TIMER_CONTROL_REG_TF1 7

// Reset values and count limits.
`define DTC_COUNT_RST 8'h00
`define DTC_TIMER_CONTROL_REG_RST 8'h00
`define DTC_BYTE_MAX 8'hFF
`define DTC_PRESC_MAX 5'h1F

`endif

// file: dtc_pkg.sv
// Types shared by the dual timer/counter modules.
package dtc_pkg;

	typedef enum logic [1:0] {
		DTC_MODE_13BIT = 2'b00,
		DTC_MODE_16BIT = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT = 2'b11
	} dtc_mode_t;

	typedef struct packed {
		logic ovf;
		logic [7:0] hi;
		logic [7:0] lo;
	} dtc_step_t;

endpackage

// file: dtc_pin_if.sv
// Conditioned view of one external pin: synchronised level and sampled falling edge.
`timescale 1ns/10ps
`default_nettype none
interface dtc_pin_if;
	logic level;
	logic fall;

	modport src (
		output level,
		output fall
	);

	modport dst (
		input level,
		input fall
	);
endinterface
`default_nettype wire

// file: dtc_pin_sampler.sv
// Synchroniser and once-per-peripheral-cycle falling-edge detector for one pin.
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_sampler (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Raw pin and sampling strobe
	input wire logic pin_raw,
	input wire logic sample_tick,
	// Conditioned result
	dtc_pin_if.src pin_o
);

	logic sync1_reg;
	logic sync2_reg;
	logic prev_reg;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prev_reg <= 1'b1;
		end else if (sample_tick) begin
			prev_reg <= sync2_reg;
		end
	end

	// A level held for a full peripheral cycle is always seen, whatever its duty cycle.
	assign pin_o.level = sync2_reg;
	assign pin_o.fall = sample_tick & prev_reg & ~sync2_reg;

	a_fall_on_tick: assert property (@(posedge clk_sys) disable iff (sys_rst)
		pin_o.fall |-> sample_tick && !sync2_reg && prev_reg)
		else $error("falling edge reported off the sampling strobe");

endmodule
`default_nettype wire

// file: dtc_dual_timer.sv
// Two timer/counters, timer 0 with four modes and timer 1 with three (its mode 3 halts it), driven by plain control and status ports.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_params.svh"
module dtc_dual_timer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Mode register and run bits written by software
	input wire logic [7:0] timer_mode_reg,
	input wire logic t0_run_bit,
	input wire logic t1_run_bit,
	// External interrupt status kept elsewhere, shown in the control view
	input wire logic ext_irq_a_edge_flag,
	input wire logic ext_irq_a_type,
	input wire logic ext_irq_b_edge_flag,
	input wire logic ext_irq_b_type,
	// External pins
	input wire logic t0_count_pin,
	input wire logic t1_count_pin,
	input wire logic ext_irq_pin_a,
	input wire logic ext_irq_pin_b,
	// Serial-port clock strobe from the same clock domain
	input wire logic uart_clk_tick,
	// Count byte writes
	input wire logic [7:0] count_wr_data,
	input wire logic t0_low_wr,
	input wire logic t0_high_wr,
	input wire logic t1_low_wr,
	input wire logic t1_high_wr,
	// Interrupt service acknowledges
	input wire logic t0_irq_ack,
	input wire logic t1_irq_ack,
	// Count bytes
	output logic [7:0] t0_low_byte,
	output logic [7:0] t0_high_byte,
	output logic [7:0] t1_low_byte,
	output logic [7:0] t1_high_byte,
	// Flags, requests and status
	output logic t0_overflow_flag,
	output logic t1_overflow_flag,
	output logic t0_irq_req,
	output logic t1_irq_req,
	output logic t1_overflow_pulse,
	output logic [7:0] timer_control_reg
);

	dtc_pin_if pin_t0 ();
	dtc_pin_if pin_t1 ();
	dtc_pin_if pin_a ();
	dtc_pin_if pin_b ();

	logic [3:0] presc_reg;
	logic periph_tick;
	logic [7:0] t0_lo_reg;
	logic [7:0] t0_hi_reg;
	logic [7:0] t1_lo_reg;
	logic [7:0] t1_hi_reg;
	logic tf0_reg;
	logic tf1_reg;
	logic baud_reg;
	logic [7:0] timer_control_reg_reg;
	dtc_pkg::dtc_mode_t t0_mode;
	dtc_pkg::dtc_mode_t t1_mode;
	logic t0_csel;
	logic t0_gate_enable;
	logic t1_csel;
	logic t1_gate_enable;
	logic t0_split;
	logic t0_en;
	logic t1_en;
	logic t0_inc;
	logic t1_inc;
	logic th0_inc;
	logic th0_ovf;
	logic tf0_set;
	logic tf1_set;
	dtc_pkg::dtc_step_t t0_step;
	dtc_pkg::dtc_step_t t1_step;
	logic t0_wr_any;
	logic t1_wr_any;

	// Peripheral cycle strobe.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			presc_reg <= 4'h0;
		end else if (presc_reg == `DTC_PERIPH_LAST) begin
			presc_reg <= 4'h0;
		end else begin
			presc_reg <= presc_reg + 4'h1;
		end
	end
	assign periph_tick = (presc_reg == `DTC_PERIPH_LAST);

	dtc_pin_sampler u_samp_t0 (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin_raw(t0_count_pin),
		.sample_tick(periph_tick),
		.pin_o(pin_t0.src)
	);
	dtc_pin_sampler u_samp_t1 (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin_raw(t1_count_pin),
		.sample_tick(periph_tick),
		.pin_o(pin_t1.src)
	);
	dtc_pin_sampler u_samp_a (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin_raw(ext_irq_pin_a),
		.sample_tick(periph_tick),
		.pin_o(pin_a.src)
	);
	dtc_pin_sampler u_samp_b (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pin_raw(ext_irq_pin_b),
		.sample_tick(periph_tick),
		.pin_o(pin_b.src)
	);

	assign t0_mode = dtc_pkg::dtc_mode_t'(timer_mode_reg[`DTC_TIMER_MODE_REG_T0_MODE_HI:`DTC_TIMER_MODE_REG_T0_MODE_LO]);
	assign t1_mode = dtc_pkg::dtc_mode_t'(timer_mode_reg[`DTC_TIMER_MODE_REG_T1_MODE_HI:`DTC_TIMER_MODE_REG_T1_MODE_LO]);
	assign t0_csel = timer_mode_reg[`DTC_TIMER_MODE_REG_T0_CSEL];
	assign t0_gate_enable = timer_mode_reg[`DTC_TIMER_MODE_REG_T0_GATE];
	assign t1_csel = timer_mode_reg[`DTC_TIMER_MODE_REG_T1_CSEL];
	assign t1_gate_enable = timer_mode_reg[`DTC_TIMER_MODE_REG_T1_GATE];
	assign t0_split = (t0_mode == dtc_pkg::DTC_MODE_SPLIT);
	assign t0_wr_any = t0_low_wr | t0_high_wr;
	assign t1_wr_any = t1_low_wr | t1_high_wr;

	assign t0_en = t0_run_bit & (~t0_gate_enable | pin_a.level);
	// run bit lent to timer 0, so timer 1 is then switched by its mode and its gate alone.
	assign t1_en = (t1_run_bit | t0_split) & (~t1_gate_enable | pin_b.level);
	assign t0_inc = t0_en & (t0_csel ? pin_t0.fall : periph_tick);
	assign t1_inc = t1_en & (t1_mode != dtc_pkg::DTC_MODE_SPLIT) & (t1_csel ? pin_t1.fall : periph_tick);
	assign th0_inc = t0_split & t1_run_bit & uart_clk_tick;
	assign th0_ovf = th0_inc & (t0_hi_reg == `DTC_BYTE_MAX);

	// One count step; the split mode only advances the low byte here.
	function automatic dtc_pkg::dtc_step_t dtc_step(input dtc_pkg::dtc_mode_t mode,
			input logic [7:0] lo, input logic [7:0] hi, input logic inc);
		dtc_pkg::dtc_step_t r;
		r.ovf = 1'b0;
		r.hi = hi;
		r.lo = lo;
		if (inc) begin
			unique case (mode)
				dtc_pkg::DTC_MODE_13BIT: begin
					r.lo = {lo[7:5], lo[4:0] + 5'h01};
					if (lo[4:0] == `DTC_PRESC_MAX) begin
						r.hi = hi + 8'h01;
						r.ovf = (hi == `DTC_BYTE_MAX);
					end
				end
				dtc_pkg::DTC_MODE_16BIT: begin
					{r.ovf, r.hi, r.lo} = {1'b0, hi, lo} + 17'h00001;
				end
				dtc_pkg::DTC_MODE_RELOAD: begin
					if (lo == `DTC_BYTE_MAX) begin
						r.lo = hi;
						r.ovf = 1'b1;
					end else begin
						r.lo = lo + 8'h01;
					end
				end
				dtc_pkg::DTC_MODE_SPLIT: begin
					r.lo = lo + 8'h01;
					r.ovf = (lo == `DTC_BYTE_MAX);
				end
			endcase
		end
		return r;
	endfunction

	always_comb begin
		t0_step = dtc_step(t0_mode, t0_lo_reg, t0_hi_reg, t0_inc);
		t1_step = dtc_step(t1_mode, t1_lo_reg, t1_hi_reg, t1_inc);
	end

	// Timer 0 counts; a software write overrides the count on its byte.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			t0_lo_reg <= `DTC_COUNT_RST;
			t0_hi_reg <= `DTC_COUNT_RST;
		end else begin
			t0_lo_reg <= t0_low_wr ? count_wr_data : t0_step.lo;
			if (t0_high_wr) begin
				t0_hi_reg <= count_wr_data;
			end else if (t0_split) begin
				t0_hi_reg <= th0_inc ? t0_hi_reg + 8'h01 : t0_hi_reg;
			end else begin
				t0_hi_reg <= t0_step.hi;
			end
		end
	end

	// Timer 1 counts.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			t1_lo_reg <= `DTC_COUNT_RST;
			t1_hi_reg <= `DTC_COUNT_RST;
		end else begin
			t1_lo_reg <= t1_low_wr ? count_wr_data : t1_step.lo;
			t1_hi_reg <= t1_high_wr ? count_wr_data : t1_step.hi;
		end
	end

	assign tf0_set = t0_step.ovf;
	assign tf1_set = t0_split ? th0_ovf : t1_step.ovf;

	// acknowledge clears flag
	// An overflow in the acknowledge cycle wins, so no event is lost.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tf0_reg <= 1'b0;
			tf1_reg <= 1'b0;
		end else begin
			tf0_reg <= tf0_set | (tf0_reg & ~t0_irq_ack);
			tf1_reg <= tf1_set | (tf1_reg & ~t1_irq_ack);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			baud_reg <= 1'b0;
		end else begin
			baud_reg <= t1_step.ovf;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			timer_control_reg_reg <= `DTC_TIMER_CONTROL_REG_RST;
		end else begin
			timer_control_reg_reg[`DTC_TIMER_CONTROL_REG_TF1] <= tf1_reg;
			timer_control_reg_reg[`DTC_TIMER_CONTROL_REG_TR1] <= t1_run_bit;
			timer_control_reg_reg[`DTC_TIMER_CONTROL_REG_TF0] <= tf0_reg;
			timer_control_reg_reg[`DTC_TIMER_CONTROL_REG_TR0] <= t0_run_bit;
			timer_control_reg_reg[`DTC_TIMER_CONTROL_REG_IE1] <= ext_irq_b_edge_flag;
			timer_control_reg_reg[`DTC_TIMER_CONTROL_REG_IT1] <= ext_irq_b_type;
			timer_control_reg_reg[`DTC_TIMER_CONTROL_REG_IE0] <= ext_irq_a_edge_flag;
			timer_control_reg_reg[`DTC_TIMER_CONTROL_REG_IT0] <= ext_irq_a_type;
		end
	end

	assign t0_low_byte = t0_lo_reg;
	assign t0_high_byte = t0_hi_reg;
	assign t1_low_byte = t1_lo_reg;
	assign t1_high_byte = t1_hi_reg;
	assign t0_overflow_flag = tf0_reg;
	assign t1_overflow_flag = tf1_reg;
	assign t0_irq_req = tf0_reg;
	assign t1_irq_req = tf1_reg;
	assign t1_overflow_pulse = baud_reg;
	assign timer_control_reg = timer_control_reg_reg;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_t0_last16;
		t0_mode == dtc_pkg::DTC_MODE_16BIT && t0_inc && !t0_wr_any;
	endsequence
	sequence s_t0_wrap16;
		s_t0_last16 ##0 t0_lo_reg == 8'hFF ##0 t0_hi_reg == 8'hFF;
	endsequence

	a_t0_wrap_flag: assert property (tf0_set |=> t0_overflow_flag && t0_irq_req)
		else $error("timer 0 wrap did not set its flag");
	a_mode0_prescale: assert property (t0_mode == dtc_pkg::DTC_MODE_13BIT && t0_inc
		&& !t0_wr_any && t0_lo_reg[4:0] == 5'h1F
		|=> t0_lo_reg[4:0] == 5'h00 && t0_hi_reg == $past(t0_hi_reg) + 8'h01)
		else $error("mode 0 prescaler carry wrong");
	a_mode1_carry: assert property (s_t0_last16 ##0 t0_lo_reg == 8'hFF
		|=> t0_lo_reg == 8'h00 && t0_hi_reg == $past(t0_hi_reg) + 8'h01)
		else $error("mode 1 carry into high byte wrong");
	a_mode2_reload: assert property (t0_mode == dtc_pkg::DTC_MODE_RELOAD && t0_inc
		&& !t0_wr_any && t0_lo_reg == 8'hFF
		|=> t0_lo_reg == $past(t0_hi_reg) && t0_overflow_flag)
		else $error("mode 2 reload wrong");
	a_reload_keeps_hi: assert property (t1_mode == dtc_pkg::DTC_MODE_RELOAD
		&& !t1_high_wr |=> t1_hi_reg == $past(t1_hi_reg))
		else $error("mode 2 altered the reload byte");
	a_ack_clears_flag: assert property (t1_irq_ack && !tf1_set |=> !t1_overflow_flag)
		else $error("acknowledge did not clear timer 1 flag");
	a_split_low_timer: assert property (t0_split && t0_inc && !t0_wr_any
		&& t0_lo_reg == 8'hFF |=> t0_lo_reg == 8'h00 && t0_overflow_flag)
		else $error("split low byte wrap wrong");
	a_split_high_uart: assert property (t0_split && uart_clk_tick && t1_run_bit
		&& !t0_high_wr && t0_hi_reg == 8'hFF |=> t0_hi_reg == 8'h00 && t1_overflow_flag)
		else $error("split high byte did not flag timer 1");
	a_t1_halt_hold: assert property (t1_mode == dtc_pkg::DTC_MODE_SPLIT && !t1_wr_any
		|=> $stable(t1_lo_reg) && $stable(t1_hi_reg))
		else $error("timer 1 moved while halted");
	a_ctrl_layout: assert property (##1 timer_control_reg[7] == $past(tf1_reg)
		&& timer_control_reg[6] == $past(t1_run_bit)
		&& timer_control_reg[3] == $past(ext_irq_b_edge_flag))
		else $error("control view bits misplaced");
	a_t1_run_gate: assert property (!t1_run_bit && !t0_split |-> !t1_inc)
		else $error("timer 1 counted while stopped");
	a_t1_wrap_flag: assert property (t1_step.ovf && !t0_split |=> t1_overflow_flag)
		else $error("timer 1 wrap did not set its flag");
	a_baud_pulse: assert property (t1_step.ovf |=> t1_overflow_pulse ##1 !t1_overflow_pulse)
		else $error("baud pulse missing or stretched");
	a_t0_run_gate: assert property (!t0_run_bit |-> !t0_inc)
		else $error("timer 0 counted while stopped");
	a_timer_source: assert property (!t0_csel && t0_inc |-> periph_tick)
		else $error("timer 0 counted off the peripheral cycle");
	a_mode_decode: assert property (s_t0_wrap16 ##0 timer_mode_reg[1:0] == 2'b01
		|=> t0_overflow_flag && t0_hi_reg == 8'h00)
		else $error("mode code 01 did not act as 16-bit");
	a_pin_gating: assert property (t1_gate_enable && !pin_b.level |-> !t1_inc)
		else $error("gated timer 1 counted with pin low");

endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the dual timer/counter block.
`timescale 1ns/10ps
`default_nettype none
`include "dtc_params.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
	$display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] mode_reg = 8'h00;
	logic run0 = 1'b0, run1 = 1'b0, pina = 1'b0, pinb = 1'b0, uart = 1'b0;
	logic cpin0 = 1'b1, cpin1 = 1'b1;
	logic [3:0] ext = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic wr0l = 1'b0, wr0h = 1'b0, wr1l = 1'b0, wr1h = 1'b0, ack0 = 1'b0, ack1 = 1'b0;
	logic [7:0] lo0, hi0, lo1, hi1, ctrl;
	logic tf0, tf1, irq0, irq1, ovp;
	logic [1:0] f_exp = 2'b00;
	logic [7:0] pulse_cnt = 8'h00;
	logic [23:0] e_sw;
	int error_cnt = 0;
	int n_tests = 0;

	always #12.5 clk_sys = ~clk_sys;

	// Baud clock pulses are counted here so every run can check them.
	always @(posedge clk_sys) begin
		if (ovp === 1'b1)
			pulse_cnt <= pulse_cnt + 8'h01;
	end

	dtc_dual_timer u_dtc_dual_timer (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .timer_mode_reg(mode_reg),
		.t0_run_bit(run0), .t1_run_bit(run1),
		.ext_irq_a_edge_flag(ext[1]), .ext_irq_a_type(ext[0]),
		.ext_irq_b_edge_flag(ext[3]), .ext_irq_b_type(ext[2]),
		.t0_count_pin(cpin0), .t1_count_pin(cpin1),
		.ext_irq_pin_a(pina), .ext_irq_pin_b(pinb), .uart_clk_tick(uart),
		.count_wr_data(wdata), .t0_low_wr(wr0l), .t0_high_wr(wr0h),
		.t1_low_wr(wr1l), .t1_high_wr(wr1h), .t0_irq_ack(ack0), .t1_irq_ack(ack1),
		.t0_low_byte(lo0), .t0_high_byte(hi0), .t1_low_byte(lo1), .t1_high_byte(hi1),
		.t0_overflow_flag(tf0), .t1_overflow_flag(tf1), .t0_irq_req(irq0),
		.t1_irq_req(irq1), .t1_overflow_pulse(ovp), .timer_control_reg(ctrl)
	);

	// Returns overflow count, high byte and low byte after k count steps.
	function automatic logic [23:0] model(logic [1:0] m, logic [7:0] h, logic [7:0] l, int k);
		logic [7:0] cnt;
		cnt = 8'h00;
		for (int i = 0; i < k; i++) begin
			case (m)
				2'd0: begin
					l[4:0] = l[4:0] + 5'h01;
					if (l[4:0] == 5'h00) begin
						h = h + 8'h01;
						if (h == 8'h00)
							cnt++;
					end
				end
				2'd1: begin
					l = l + 8'h01;
					if (l == 8'h00) begin
						h = h + 8'h01;
						if (h == 8'h00)
							cnt++;
					end
				end
				2'd2: begin
					if (l == 8'hFF) begin
						l = h;
						cnt++;
					end else
						l = l + 8'h01;
				end
				default: begin
					l = l + 8'h01;
					if (l == 8'h00)
						cnt++;
				end
			endcase
		end
		return {cnt, h, l};
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic wr_cnt(input int t, input logic hi, input logic [7:0] d);
		@(posedge clk_sys);
		wdata <= d;
		{wr1h, wr1l, wr0h, wr0l} <= 4'h1 << (2 * t + hi);
		@(posedge clk_sys);
		{wr1h, wr1l, wr0h, wr0l} <= 4'h0;
	endtask

	task automatic ack(input int t);
		@(posedge clk_sys);
		if (t == 1) ack1 <= 1'b1; else ack0 <= 1'b1;
		@(posedge clk_sys);
		ack0 <= 1'b0;
		ack1 <= 1'b0;
	endtask

	task automatic set_run(input int t, input logic v);
		@(posedge clk_sys);
		if (t == 1) run1 <= v; else run0 <= v;
	endtask

	task automatic set_mode(input int t, input logic g, input logic c, input logic [1:0] m);
		@(posedge clk_sys);
		if (t == 1) mode_reg[7:4] <= {g, c, m}; else mode_reg[3:0] <= {g, c, m};
	endtask

	task automatic prep(input int t, input logic [7:0] h, input logic [7:0] l);
		wr_cnt(t, 1'b0, l);
		wr_cnt(t, 1'b1, h);
		ack(t);
		tick(4);
		// Service acknowledge clears flag.
		`CHK((t == 1) ? tf1 : tf0, 1'b0)
		f_exp[t] = 1'b0;
		pulse_cnt = 8'h00;
	endtask

	task automatic run_case(input int t, input logic [1:0] m, input logic g, input logic pin,
		input logic [7:0] h, input logic [7:0] l, input int k);
		logic [23:0] e;
		set_mode(t, g, 1'b0, m);
		@(posedge clk_sys);
		pina <= pin;
		pinb <= pin;
		ext <= 4'($urandom);
		prep(t, h, l);
		e = ((g && !pin) || (t == 1 && m == 2'd3)) ? {8'h00, h, l} : model(m, h, l, k);
		// Exactly k peripheral cycles fall inside a window of 12k clocks.
		set_run(t, 1'b1);
		tick(12 * k - 1);
		set_run(t, 1'b0);
		tick(3);
		if (e[23:16] != 8'h00)
			f_exp[t] = 1'b1;
		`CHK((t == 1) ? lo1 : lo0, e[7:0])
		`CHK((t == 1) ? hi1 : hi0, e[15:8])
		`CHK((t == 1) ? tf1 : tf0, f_exp[t])
		`CHK((t == 1) ? irq1 : irq0, f_exp[t])
		`CHK(pulse_cnt, (t == 1) ? e[23:16] : 8'h00)
		`CHK(ctrl, {f_exp[1], 1'b0, f_exp[0], 1'b0, ext})
	endtask

	task automatic cnt_case(input int t, input int n);
		set_mode(t, 1'b0, 1'b1, 2'd1);
		prep(t, 8'h00, 8'h00);
		set_run(t, 1'b1);
		repeat (n) begin
			@(posedge clk_sys);
			if (t == 1) cpin1 <= 1'b0; else cpin0 <= 1'b0;
			tick(24);
			cpin0 <= 1'b1;
			cpin1 <= 1'b1;
			tick(24);
		end
		`CHK(ctrl[(t == 1) ? `DTC_TIMER_CONTROL_REG_TR1 : `DTC_TIMER_CONTROL_REG_TR0], 1'b1)
		set_run(t, 1'b0);
		tick(3);
		// One count per sampled falling edge.
		`CHK((t == 1) ? lo1 : lo0, 8'(n))
	endtask

	task automatic test_done;
		$display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#2500000;
		error_cnt++;
		test_done;
	end

	initial begin
		void'($urandom(32'h18597E62));
		tick(16);
		sys_rst <= 1'b0;
		tick(3);
		`CHK({lo0, hi0, lo1, hi1}, {4{`DTC_COUNT_RST}})
		`CHK({tf0, tf1, ovp, ctrl}, {3'b000, `DTC_TIMER_CONTROL_REG_RST})
		for (int t = 0; t < 2; t++) begin
			// Mode 0 wrap with upper low bits held, mode 1 wrap, mode 2 reloads.
			run_case(t, 2'd0, 1'b0, 1'b0, 8'hFF, 8'hFE, 3);
			run_case(t, 2'd1, 1'b0, 1'b0, 8'hFF, 8'hFE, 3);
			run_case(t, 2'd2, 1'b0, 1'b0, 8'hFE, 8'hFD, 6);
			// Gate set: low pin blocks counting, high pin allows it.
			run_case(t, 2'd1, 1'b1, 1'b0, 8'h12, 8'h34, 3);
			run_case(t, 2'd1, 1'b1, 1'b1, 8'h12, 8'hFF, 3);
			cnt_case(t, 3);
		end
		repeat (10)
			run_case($urandom % 2, 2'($urandom % 3), 1'($urandom), 1'($urandom),
				8'($urandom), 8'($urandom), 1 + $urandom % 8);
		run_case(1, 2'd3, 1'b0, 1'b0, 8'hA5, 8'h5A, 2);
		run_case(0, 2'd3, 1'b0, 1'b0, 8'hFD, 8'hFE, 4);
		ack(1);
		set_run(1, 1'b1);
		repeat (5) begin
			@(posedge clk_sys);
			uart <= 1'b1;
			@(posedge clk_sys);
			uart <= 1'b0;
			tick(2);
		end
		`CHK(ctrl[`DTC_TIMER_CONTROL_REG_TR1], 1'b1)
		set_run(1, 1'b0);
		tick(3);
		// Split high byte counts serial ticks and raises the timer 1 flag.
		`CHK(hi0, 8'h02)
		`CHK(tf1, 1'b1)
		`CHK({hi1, lo1}, 16'hA55A)
		ack(1);
		set_mode(1, 1'b0, 1'b0, 2'd2);
		tick(12 * 170 - 1);
		set_mode(1, 1'b0, 1'b0, 2'd3);
		tick(3);
		e_sw = model(2'd2, 8'hA5, 8'h5A, 170);
		// Out of mode 3 timer 1 runs without its run bit and only pulses the baud clock.
		`CHK({hi1, lo1}, e_sw[15:0])
		`CHK(pulse_cnt, e_sw[23:16])
		`CHK(tf1, 1'b0)
		test_done;
	end
endmodule
`default_nettype wire
